// [design/i2s_port_pkg.sv]
// Shared constants for the stereo serial audio port.
// Functional notes
// [RULE1] Master drives bit clock and word select; slave takes both as inputs.
// [RULE2] Serial data output is always driven, whatever the role.
// [RULE3] Each channel sample is 16 bits, MSB in the first data bit of the slot.
// [RULE4] MSB of a new word appears one bit period after word select changes, on a fall.
// [RULE5] Left channel while word select is low, right channel while it is high.
// [RULE6] The peer captures each output bit on the next rising bit-clock edge.
// [RULE7] Master frames run at 48 kHz with 32 or 50 bit periods per frame.
// [RULE8] Master bit clock comes from the reference clock by an N/M fractional divider.
// [RULE9] Slave works with any external bit clock up to 3.072 MHz.
// [RULE10] Master bit clock high and low phases each last at least 0.35 of the period.
// [RULE11] Input data is captured on rising edges, assembled MSB first, handed on per slot.
// [RULE12] Slot bit periods after the sixteenth data bit carry zero.
package i2s_port_pkg;

  localparam int SYS_CLK_HZ       = 20000000;
  localparam int FRAME_RATE_HZ    = 48000;
  localparam int FRAME_BITS_SHORT = 32;
  localparam int FRAME_BITS_LONG  = 50;
  localparam int SLAVE_MAX_BCLK_HZ = 3072000;

  localparam int SAMPLE_BITS = 16;
  localparam int FIFO_WORDS  = 4;

  // The divider accumulator must hold the reference rate plus one step.
  localparam int ACC_W = 26;

  // Each accumulator overflow is one half bit period, so the step is twice the bit rate.
  localparam logic [ACC_W-1:0] DIV_M       = ACC_W'(SYS_CLK_HZ);
  localparam logic [ACC_W-1:0] DIV_N_SHORT = ACC_W'(2 * FRAME_RATE_HZ * FRAME_BITS_SHORT);
  localparam logic [ACC_W-1:0] DIV_N_LONG  = ACC_W'(2 * FRAME_RATE_HZ * FRAME_BITS_LONG);

  localparam int FRAME_CNT_W = 6;
  localparam logic [FRAME_CNT_W-1:0] FRAME_LAST_SHORT = FRAME_CNT_W'(FRAME_BITS_SHORT - 1);
  localparam logic [FRAME_CNT_W-1:0] FRAME_LAST_LONG  = FRAME_CNT_W'(FRAME_BITS_LONG - 1);
  localparam logic [FRAME_CNT_W-1:0] FRAME_HALF_SHORT = FRAME_CNT_W'(FRAME_BITS_SHORT / 2);
  localparam logic [FRAME_CNT_W-1:0] FRAME_HALF_LONG  = FRAME_CNT_W'(FRAME_BITS_LONG / 2);

  // Fewest reference cycles in half a slave bit period at the top slave rate.
  localparam int SLAVE_MIN_HALF_CYCLES = SYS_CLK_HZ / (2 * SLAVE_MAX_BCLK_HZ);

endpackage

// [design/sample_fifo.sv]
// Small synchronous FIFO with valid/ready handshakes on both sides.
`timescale 1ns/1ps
module sample_fifo
  import i2s_port_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = FIFO_WORDS
)
(
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr_ptr;
    logic [PW-1:0]               rd_ptr;
    logic [CW-1:0]               count;
    logic                        in_rdy;
  } fifo_state_t;

  fifo_state_t s;
  fifo_state_t next_s;
  logic        push;
  logic        pop;

  always_comb
  begin
    next_s = s;
    push   = in_valid && s.in_rdy;
    pop    = out_ready && (s.count != '0);
    if (push)
    begin
      next_s.mem[s.wr_ptr] = in_data;
      next_s.wr_ptr        = (s.wr_ptr == PW'(DEPTH - 1)) ? '0 : s.wr_ptr + 1'b1;
    end
    if (pop)
    begin
      next_s.rd_ptr = (s.rd_ptr == PW'(DEPTH - 1)) ? '0 : s.rd_ptr + 1'b1;
    end
    if (push && !pop)
    begin
      next_s.count = s.count + 1'b1;
    end
    else if (pop && !push)
    begin
      next_s.count = s.count - 1'b1;
    end
    // Ready is registered from the next count, so the source sees a flop with no extra cycle of latency.
    next_s.in_rdy = (next_s.count != CW'(DEPTH));
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign in_ready  = s.in_rdy;
  assign out_valid = (s.count != '0);
  assign out_data  = s.mem[s.rd_ptr];

endmodule

// [design/i2s_stereo_port.sv]
// Stereo serial audio port with master and slave roles, transmit FIFO and receive path.
`timescale 1ns/1ps
module i2s_stereo_port
  import i2s_port_pkg::*;
#(
  parameter int SAMPLE_W   = SAMPLE_BITS,
  parameter int FIFO_DEPTH = FIFO_WORDS
)
(
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  input  wire logic                master_mode,
  input  wire logic                long_frame,
  input  wire logic                sck_in,
  output logic                     sck_out,
  output logic                     sck_oe,
  input  wire logic                ws_in,
  output logic                     ws_out,
  output logic                     ws_oe,
  output logic                     sdo,
  input  wire logic                sdi,
  input  wire logic                tx_valid,
  output logic                     tx_ready,
  input  wire logic [SAMPLE_W-1:0] tx_left,
  input  wire logic [SAMPLE_W-1:0] tx_right,
  output logic                     rx_valid,
  output logic      [SAMPLE_W-1:0] rx_data,
  output logic                     rx_right
);

  localparam int CNT_W = $clog2(SAMPLE_W + 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(SAMPLE_W);

  typedef struct packed {
    logic [ACC_W-1:0]       acc;
    logic                   bclk;
    logic                   clk_prev;
    logic [FRAME_CNT_W-1:0] bit_cnt;
    logic                   ws_gen;
    logic                   ws_rise;
    logic                   ws_slot;
    logic [SAMPLE_W-1:0]    tx_shift;
    logic [CNT_W-1:0]       tx_cnt;
    logic [SAMPLE_W-1:0]    right_hold;
    logic                   sdo;
    logic [SAMPLE_W-1:0]    rx_shift;
    logic [CNT_W-1:0]       rx_cnt;
    logic                   rx_armed;
    logic                   rx_valid;
    logic [SAMPLE_W-1:0]    rx_data;
    logic                   rx_right;
    logic                   sck_oe;
    logic                   ws_oe;
  } port_state_t;

  port_state_t s;
  port_state_t next_s;

  logic                  fifo_out_valid;
  logic                  fifo_pop;
  logic [2*SAMPLE_W-1:0] fifo_out_data;

  sample_fifo #(
    .WIDTH (2 * SAMPLE_W),
    .DEPTH (FIFO_DEPTH)
  ) tx_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   ({tx_left, tx_right}),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  logic                   eff_clk;
  logic                   eff_ws;
  logic                   clk_rise;
  logic                   clk_fall;
  logic [ACC_W-1:0]       acc_sum;
  logic [ACC_W-1:0]       div_step;
  logic [FRAME_CNT_W-1:0] frame_last;
  logic [FRAME_CNT_W-1:0] frame_half;
  logic [FRAME_CNT_W-1:0] cnt_adv;
  logic [SAMPLE_W-1:0]    tx_word;
  logic [SAMPLE_W-1:0]    rx_word;
  logic [CNT_W-1:0]       rx_cnt_adv;

  always_comb
  begin
    next_s     = s;
    fifo_pop   = 1'b0;
    tx_word    = '0;
    rx_word    = s.rx_shift;
    rx_cnt_adv = s.rx_cnt;
    div_step   = long_frame ? DIV_N_LONG : DIV_N_SHORT;
    frame_last = long_frame ? FRAME_LAST_LONG : FRAME_LAST_SHORT;
    frame_half = long_frame ? FRAME_HALF_LONG : FRAME_HALF_SHORT;
    acc_sum    = s.acc + div_step;
    cnt_adv    = (s.bit_cnt >= frame_last) ? '0 : s.bit_cnt + 1'b1;

    // Role selects who owns the clock and word select pins.
    next_s.sck_oe = master_mode; // RULE1
    next_s.ws_oe  = master_mode; // RULE1

    // Fractional N/M divider: each wrap of the accumulator toggles the bit clock.
    // Half periods differ by at most one reference cycle, which keeps each phase
    // near half the period, well above the 0.35 floor.
    if (master_mode)
    begin
      if (acc_sum >= DIV_M) // RULE8
      begin
        next_s.acc  = acc_sum - DIV_M; // RULE8
        next_s.bclk = !s.bclk; // RULE10
        if (s.bclk)
        begin
          // Word select moves on the falling edge; the frame is 32 or 50 bits.
          next_s.bit_cnt = cnt_adv; // RULE7
          next_s.ws_gen  = (cnt_adv >= frame_half); // RULE5
        end
      end
      else
      begin
        next_s.acc = acc_sum;
      end
    end
    else
    begin
      next_s.acc     = '0;
      next_s.bclk    = 1'b0;
      next_s.bit_cnt = '0;
      next_s.ws_gen  = 1'b0;
    end

    // In slave mode the external clock is sampled by the reference clock, which
    // resolves edges only up to the slave rate limit.
    eff_clk         = master_mode ? s.bclk : sck_in; // RULE9
    eff_ws          = master_mode ? s.ws_gen : ws_in;
    clk_rise        = eff_clk && !s.clk_prev;
    clk_fall        = !eff_clk && s.clk_prev;
    next_s.clk_prev = eff_clk;
    next_s.rx_valid = 1'b0;

    if (clk_rise)
    begin
      next_s.ws_rise = eff_ws;
      // Capture the input bit on the rising edge, MSB first.
      if (s.rx_cnt < CNT_FULL)
      begin
        rx_word    = {s.rx_shift[SAMPLE_W-2:0], sdi}; // RULE11
        rx_cnt_adv = s.rx_cnt + 1'b1;
      end
      next_s.rx_shift = rx_word;
      next_s.rx_cnt   = rx_cnt_adv;
      if (eff_ws != s.ws_rise)
      begin
        // With 16-bit slots the bit taken at the word select change is still the old word's LSB.
        if (s.rx_armed && (rx_cnt_adv == CNT_FULL))
        begin
          next_s.rx_valid = 1'b1; // RULE11
          next_s.rx_data  = rx_word;
          next_s.rx_right = s.ws_rise; // RULE5
        end
        next_s.rx_cnt   = '0;
        next_s.rx_armed = 1'b1;
      end
    end

    if (clk_fall)
    begin
      if (s.ws_rise != s.ws_slot)
      begin
        // A change seen at the last rise means this fall carries the new MSB.
        next_s.ws_slot = s.ws_rise; // RULE4
        if (!s.ws_rise)
        begin
          // A pair leaves the FIFO at each left slot; empty means silence.
          fifo_pop = fifo_out_valid;
          if (fifo_out_valid)
          begin
            tx_word           = fifo_out_data[2*SAMPLE_W-1:SAMPLE_W]; // RULE5
            next_s.right_hold = fifo_out_data[SAMPLE_W-1:0];
          end
          else
          begin
            next_s.right_hold = '0;
          end
        end
        else
        begin
          tx_word = s.right_hold; // RULE5
        end
        next_s.sdo      = tx_word[SAMPLE_W-1]; // RULE3
        next_s.tx_shift = {tx_word[SAMPLE_W-2:0], 1'b0};
        next_s.tx_cnt   = CNT_W'(1);
      end
      else if (s.tx_cnt < CNT_FULL)
      begin
        next_s.sdo      = s.tx_shift[SAMPLE_W-1]; // RULE6
        next_s.tx_shift = {s.tx_shift[SAMPLE_W-2:0], 1'b0};
        next_s.tx_cnt   = s.tx_cnt + 1'b1;
      end
      else
      begin
        next_s.sdo = 1'b0; // RULE12
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign sck_out  = s.bclk;
  assign sck_oe   = s.sck_oe;
  assign ws_out   = s.ws_gen;
  assign ws_oe    = s.ws_oe;
  // The data line has no enable of its own: it is driven in both roles.
  assign sdo      = s.sdo; // RULE2
  assign rx_valid = s.rx_valid;
  assign rx_data  = s.rx_data;
  assign rx_right = s.rx_right;

endmodule

// [verif/i2s_port_sva.sv]
// Pin-level assertions for the stereo serial audio port.
`timescale 1ns/1ps
module i2s_port_sva (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic master_mode,
  input wire logic long_frame,
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic ws_out,
  input wire logic ws_oe,
  input wire logic sdo,
  input wire logic rx_valid,
  input wire logic rx_right
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic       ws_q;
  logic       armed;
  logic [9:0] cnt;
  // The first half frame after reset is partial, so it is never measured.
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      ws_q  <= 1'b0;
      armed <= 1'b0;
      cnt   <= 10'h0;
    end
    else
    begin
      ws_q  <= ws_out;
      armed <= armed | (ws_out != ws_q);
      cnt   <= (ws_out != ws_q) ? 10'h1 : cnt + 10'h1;
    end
  a_oe_master: assert property (master_mode |=> sck_oe && ws_oe)
    else $error("clock pins not driven in master role");
  a_oe_slave: assert property (!master_mode |=> !sck_oe && !ws_oe && !sck_out)
    else $error("clock pins driven in slave role");
  a_high_phase: assert property (master_mode && !long_frame && $rose(sck_out) |-> sck_out[*5])
    else $error("bit clock high phase too short");
  a_low_phase: assert property (master_mode && long_frame && $fell(sck_out) |-> !sck_out[*4])
    else $error("bit clock low phase too short");
  a_sdo_on_fall: assert property (master_mode && $changed(sdo) |-> !sck_out && !$past(sck_out))
    else $error("data changed outside the low phase");
  a_ws_on_fall: assert property (master_mode && $changed(ws_out) |-> !sck_out)
    else $error("word select changed outside the low phase");
  a_half_frame: assert property (master_mode && armed && ws_out != ws_q |-> cnt inside {[206:210]})
    else $error("half frame length off the frame rate");
  a_rx_slot: assert property (master_mode && rx_valid |-> rx_right == !ws_out)
    else $error("received slot side wrong");
endmodule

// [verif/codec_model.sv]
// Behavioural stereo codec on the far side of the serial link.
`timescale 1ns/1ps
module codec_model
  import i2s_port_pkg::*;
(
  input  wire logic sck,
  input  wire logic ws,
  input  wire logic sdo,
  input  wire logic gen_on,
  output logic      sck_in,
  output logic      ws_in,
  output logic      sdi
);
  localparam int CLK_NS = 1000000000 / SYS_CLK_HZ;
  int          half_ns, sbits, n, k, fn, zero_err, step;
  logic        wp, armed, fresh;
  logic [15:0] word;
  logic [15:0] txw = 16'h1234;
  logic [23:0] got_q[$];
  logic [16:0] sent_q[$];
  function automatic void clear(input int h, input int b);
    half_ns = h;
    sbits = b;
    {n, fn, zero_err} = '0;
    {wp, armed, fresh, sck_in, ws_in, sdi} = '0;
    got_q.delete();
    sent_q.delete();
  endfunction
  // The clock stands still while generation is off.
  always
  begin
    step = (half_ns > 0) ? half_ns : 1;
    // The port samples these pins without a synchroniser, so no toggle may land on its edge.
    if ((($time + step) % CLK_NS) == CLK_NS / 2)
      step++;
    #(step);
    sck_in = gen_on & ~sck_in;
    if (gen_on && !sck_in)
    begin
      fn++;
      if (fn == sbits)
      begin
        fn = 0;
        ws_in = ~ws_in;
      end
    end
  end
  always @(posedge sck)
  begin
    if (n < 16)
      word = {word[14:0], sdo};
    else if (sdo)
      zero_err++;
    n++;
    if (ws != wp)
    begin
      if (armed)
        got_q.push_back({7'(n), wp, word});
      n = 0;
      wp = ws;
      armed = 1'b1;
      fresh = 1'b1;
    end
  end
  always @(negedge sck)
  begin
    if (fresh)
    begin
      fresh = 1'b0;
      k = 0;
      txw = txw + 16'h3b5d;
      sent_q.push_back({wp, txw});
    end
    // Past the sixteenth bit the line toggles, so a stuck capture cannot pass.
    sdi = (k < 16) ? txw[15 - k] : ~sdi;
    k++;
  end
endmodule

// [verif/testbench.sv]
// Self-checking bench for the stereo serial audio port.
`timescale 1ns/1ps
module testbench;
  import i2s_port_pkg::*;
  logic        sys_clk, rst_n, master_mode, long_frame, tx_valid;
  logic [15:0] tx_left, tx_right, cur_r, e;
  logic [23:0] g;
  logic [16:0] s;
  logic [31:0] pairs_q[$];
  wire         sck_out, sck_oe, ws_out, ws_oe, sdo, sdi, tx_ready, rx_valid, rx_right;
  wire         sck_in, ws_in;
  wire  [15:0] rx_data;
  wire         sck_w = sck_oe ? sck_out : sck_in;
  wire         ws_w = ws_oe ? ws_out : ws_in;
  int          fail_count = 0;
  int          n_checks = 0;
  int          seed = 39532;
  int          nbits;
  int          tx_seen, rx_seen;
  i2s_stereo_port i2s_stereo_port_inst (.sys_clk, .rst_n, .master_mode, .long_frame,
    .sck_in, .sck_out, .sck_oe, .ws_in, .ws_out, .ws_oe, .sdo, .sdi, .tx_valid,
    .tx_ready, .tx_left, .tx_right, .rx_valid, .rx_data, .rx_right);
  codec_model codec_model_inst (.sck(sck_w), .ws(ws_w), .sdo, .gen_on(rst_n & ~master_mode),
    .sck_in, .ws_in, .sdi);
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [23:0] ex, input logic [23:0] got);
    n_checks++;
    if (ex !== got)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask
  always @(posedge sys_clk)
  begin
    if (rx_valid === 1'b1)
    begin
      rx_seen++;
      // A word handed on with nothing sent for it is a fault of its own.
      chk("rx_expected", 24'h1, {23'h0, codec_model_inst.sent_q.size() > 0});
      if (codec_model_inst.sent_q.size() > 0)
      begin
        s = codec_model_inst.sent_q.pop_front();
        chk("rx_word", {7'h0, s}, {7'h0, rx_right, rx_data});
      end
    end
    while (codec_model_inst.got_q.size() > 0)
    begin
      g = codec_model_inst.got_q.pop_front();
      tx_seen++;
      e = cur_r;
      // An empty queue at a left slot means silence on both channels.
      if (!g[16])
        {e, cur_r} = (pairs_q.size() > 0) ? pairs_q.pop_front() : 32'h0;
      chk("tx_slot", {7'(nbits), g[16], e}, g);
    end
  end
  task automatic push(input int cnt);
    repeat (cnt)
    begin
      tx_left = 16'($random(seed));
      tx_right = 16'($random(seed));
      tx_valid = 1'b1;
      do @(negedge sys_clk); while (tx_ready !== 1'b1);
      @(posedge sys_clk);
      #2;
      pairs_q.push_back({tx_left, tx_right});
    end
    tx_valid = 1'b0;
  endtask
  task automatic run(input logic m, input logic lf, input int half, input int nb);
    #2;
    {rst_n, tx_valid, tx_left, tx_right, cur_r} = '0;
    tx_seen = 0;
    rx_seen = 0;
    master_mode = m;
    long_frame = lf;
    nbits = nb;
    pairs_q.delete();
    codec_model_inst.clear(half, nb);
    repeat (5) @(posedge sys_clk);
    #2;
    rst_n = 1'b1;
    push(4);
    repeat (2) @(negedge sys_clk);
    chk("tx_ready_full", 24'h0, {23'h0, tx_ready});
    @(posedge sys_clk);
    #2;
    push(3);
    repeat (6000) @(posedge sys_clk);
    chk("zero_tail", 24'h0, 24'(codec_model_inst.zero_err));
    // A dead link would leave both queues empty, so the slot counts are checked too.
    chk("tx_slots", 24'h1, {23'h0, tx_seen >= 20});
    chk("rx_words", 24'h1, {23'h0, rx_seen >= 20});
    $display("test master=%0d long=%0d done", m, lf);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    run(1'b1, 1'b0, 163, 16);
    run(1'b1, 1'b1, 163, 25);
    run(1'b0, 1'b0, 163, 20);
    run(1'b0, 1'b0, 400, 16);
    results();
  end
  initial
  begin
    #3000000;
    fail_count++;
    results();
  end
endmodule
bind i2s_stereo_port i2s_port_sva i2s_port_sva_inst (.sys_clk, .rst_n, .master_mode,
  .long_frame, .sck_out, .sck_oe, .ws_out, .ws_oe, .sdo, .rx_valid, .rx_right);
